// ---- inc/hbu_pkg.sv ----
// constants, types and register map of the host bus unit register set
package hbu_pkg;
   localparam logic [7:0] OFS_COMMAND = 8'h00;
   localparam logic [7:0] OFS_IN_Q = 8'h04;
   localparam logic [7:0] OFS_OUT_Q = 8'h08;
   localparam logic [7:0] OFS_FLAG_NORM = 8'h0C;
   localparam logic [7:0] OFS_FLAG_CLR = 8'h10;
   localparam logic [7:0] OFS_FLAG_SET = 8'h14;
   localparam logic [7:0] OFS_MASK_NORM = 8'h18;
   localparam logic [7:0] OFS_MASK_CLR = 8'h1C;
   localparam logic [7:0] OFS_MASK_SET = 8'h20;
   localparam logic [7:0] OFS_TRIG = 8'h24;
   localparam logic [7:0] OFS_W0_HOST = 8'h40;
   localparam logic [7:0] OFS_W0_SPAN = 8'h44;
   localparam logic [7:0] OFS_W1_HOST = 8'h48;
   localparam logic [7:0] OFS_W1_SPAN = 8'h4C;
   localparam logic [7:0] OFS_W0_MEM = 8'h50;
   localparam logic [7:0] OFS_W1_MEM = 8'h54;
   localparam logic [7:0] OFS_WIN_EN = 8'h58;
   localparam logic [7:0] OFS_IN_THR = 8'h80;
   localparam logic [7:0] OFS_OUT_THR = 8'h84;
   localparam logic [7:0] OFS_IN_DMA = 8'h88;
   localparam logic [7:0] OFS_OUT_DMA = 8'h8C;
   localparam logic [7:0] OFS_DMA_CTL = 8'h90;
   localparam logic [7:0] OFS_BEHAV = 8'h94;
   localparam logic [7:0] OFS_DEBUG = 8'h98;

   localparam logic [31:0] RST_COMMAND = 32'h0000_00FF;
   localparam logic [31:0] RST_FLAG = 32'h2040_0000;
   localparam logic [31:0] RST_MASK = 32'h0000_0000;
   localparam logic [31:0] RST_TRIG = 32'hFFFF_FFFF;
   localparam logic [20:0] RST_W0_HOST = 21'h01_0000;
   localparam logic [20:0] RST_W0_SPAN = 21'h02_0000;
   localparam logic [20:0] RST_W1_HOST = 21'h05_0000;
   localparam logic [20:0] RST_W1_SPAN = 21'h00_0001;
   localparam logic [23:0] RST_W0_MEM = 24'h00_0000;
   localparam logic [23:0] RST_W1_MEM = 24'h10_0000;
   localparam logic [7:0] RST_IN_UP = 8'h0C;
   localparam logic [7:0] RST_IN_LO = 8'h03;
   localparam logic [7:0] RST_OUT_UP = 8'h3C;
   localparam logic [7:0] RST_OUT_LO = 8'h0F;
   localparam logic [7:0] RST_IN_DMA = 8'h0A;
   localparam logic [7:0] RST_OUT_DMA = 8'h3C;
   localparam logic [4:0] RST_STOP_LEN = 5'h07;
   localparam logic [31:0] RST_BEHAV = 32'h2040_0000;
   localparam logic [7:0] CODE_NOP = 8'hFF;
   localparam logic [7:0] CODE_SW_RESET = 8'h00;

   // flag bit positions of the queue threshold flags
   localparam int FLAG_IN_HIGH = 0;
   localparam int FLAG_IN_LOW = 1;
   localparam int FLAG_OUT_HIGH = 2;
   localparam int FLAG_OUT_LOW = 3;

   localparam int Q_WIDTH = 32;
   localparam int Q_DEPTH = 8;
   localparam int Q_AW = 3;

   typedef struct packed {
      logic [4:0] stop_len;
      logic float_pins;
      logic polarity_flip;
      logic demand_mode;
      logic enable;
      logic to_input;
   } dma_ctl_t;

   localparam dma_ctl_t RST_DMA_CTL = '{stop_len: RST_STOP_LEN, float_pins: 1'b0,
      polarity_flip: 1'b0, demand_mode: 1'b0, enable: 1'b0, to_input: 1'b1};

   typedef struct packed {
      logic [20:0] host_base;
      logic [20:0] span;
      logic [23:0] mem_base;
   } window_t;

   typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_STOP} dma_state_t;
endpackage

// ---- src/hbu_fifo.sv ----
// parameterised valid/ready queue
`timescale 1ns/1ps
module hbu_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] count
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = 32'(cnt_r) != DEPTH;
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rd_r];
   assign count = cnt_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else if (flush) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= AW'(32'(wr_r) == DEPTH - 1 ? 0 : 32'(wr_r) + 1);
         end
         if (pop) begin
            rd_r <= AW'(32'(rd_r) == DEPTH - 1 ? 0 : 32'(rd_r) + 1);
         end
         cnt_r <= (AW + 1)'(32'(cnt_r) + 32'(push) - 32'(pop));
      end
   end
endmodule

// ---- src/host_bus_unit.sv ----
// host bus unit register set with queues and dma handshake
`timescale 1ns/1ps
module host_bus_unit
   import hbu_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   // host bus
   input wire logic [7:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [3:0] host_be,
   input wire logic [31:0] host_wdata,
   output logic [31:0] host_rdata,
   output logic host_in_ready,
   output logic host_size_err,
   // core side of the queues, flags and command
   output logic core_in_valid,
   input wire logic core_in_ready,
   output logic [31:0] core_in_data,
   input wire logic core_out_valid,
   output logic core_out_ready,
   input wire logic [31:0] core_out_data,
   input wire logic [7:0] in_load_cmd,
   input wire logic [31:0] core_flag_set,
   output logic [31:0] flag_dynamic,
   output logic [31:0] command_word,
   output logic command_strobe,
   // memory window mapping
   input wire logic mem_req,
   input wire logic [20:0] mem_host_addr,
   output logic mem_hit,
   output logic [23:0] mem_addr,
   // host dma acknowledge, asynchronous
   input wire logic dma_ack_pin,
   // pins, enables low while driven
   output logic dma_request_out,
   output logic dma_request_oe_b,
   output logic dma_stop_out,
   output logic dma_stop_oe_b,
   output logic interrupt_out,
   output logic interrupt_oe_b
);
   logic [31:0] command_r;
   logic [31:0] flag_r;
   logic [31:0] mask_r;
   logic [31:0] trig_r;
   logic [31:0] behav_r;
   window_t win_r [2];
   logic win_en_r;
   logic [7:0] in_up_r, in_lo_r, out_up_r, out_lo_r;
   logic [7:0] in_dma_r, out_dma_r;
   dma_ctl_t dma_r;
   logic [31:0] flag_prev_r;
   logic [4:0] stop_cnt_r;
   dma_state_t dma_state_r;
   logic ack_meta_r, ack_sync_r, ack_prev_r;
   logic en_prev_r;
   logic cmd_strobe_r;

   logic [31:0] be_mask;
   logic [31:0] wdata_m;
   logic wr_ok;
   logic sw_reset;
   logic in_push, out_pop;
   logic [Q_AW:0] in_cnt, out_cnt;
   logic [7:0] in_load, out_load;
   logic out_valid;
   logic [31:0] out_data;
   logic [31:0] hw_flags;
   logic [31:0] irq_src;
   logic irq_raw, dreq_raw, dma_stop_pulse_len_raw;
   logic dma_go;
   logic ack_rise;

   // byte lane mask; queue ports demand all four lanes
   generate
      for (genvar b = 0; b < 4; b++) begin : g_lane
         assign be_mask[8*b +: 8] = {8{host_be[b]}};
      end
   endgenerate
   assign wr_ok = host_wr;
   assign wdata_m = host_wdata & be_mask;
   assign host_size_err = (host_wr || host_rd) && ((host_addr == OFS_IN_Q) || (host_addr == OFS_OUT_Q))
      && (host_be != 4'hF);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m, input logic [31:0] d);
      merge = (old & ~m) | (d & m);
   endfunction

   // ------------------------------------------------------------
   // queues
   // ------------------------------------------------------------
   assign in_push = host_wr && host_addr == OFS_IN_Q && host_be == 4'hF;
   assign out_pop = host_rd && host_addr == OFS_OUT_Q && host_be == 4'hF && out_valid;
   assign sw_reset = cmd_strobe_r && command_r[7:0] == CODE_SW_RESET;

   hbu_fifo #(.WIDTH(Q_WIDTH), .DEPTH(Q_DEPTH), .AW(Q_AW)) u_in_q (
      .core_clk(core_clk), .rst_b(rst_b), .flush(sw_reset),
      .in_valid(in_push), .in_ready(host_in_ready), .in_data(host_wdata),
      .out_valid(core_in_valid), .out_ready(core_in_ready), .out_data(core_in_data),
      .count(in_cnt)
   );
   hbu_fifo #(.WIDTH(Q_WIDTH), .DEPTH(Q_DEPTH), .AW(Q_AW)) u_out_q (
      .core_clk(core_clk), .rst_b(rst_b), .flush(sw_reset),
      .in_valid(core_out_valid), .in_ready(core_out_ready), .in_data(core_out_data),
      .out_valid(out_valid), .out_ready(out_pop), .out_data(out_data),
      .count(out_cnt)
   );
   assign in_load = 8'(in_cnt);
   assign out_load = 8'(out_cnt);

   // ------------------------------------------------------------
   // flag sources
   // ------------------------------------------------------------
   always_comb begin
      hw_flags = core_flag_set;
      hw_flags[FLAG_IN_HIGH] = core_flag_set[FLAG_IN_HIGH] | (in_load >= in_up_r);
      hw_flags[FLAG_IN_LOW] = core_flag_set[FLAG_IN_LOW] | (in_load <= in_lo_r);
      hw_flags[FLAG_OUT_HIGH] = core_flag_set[FLAG_OUT_HIGH] | (out_load >= out_up_r);
      hw_flags[FLAG_OUT_LOW] = core_flag_set[FLAG_OUT_LOW] | (out_load <= out_lo_r);
   end
   assign flag_dynamic = behav_r;

   // ------------------------------------------------------------
   // register writes, any time, no lock
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         command_r <= RST_COMMAND;
         cmd_strobe_r <= 1'b0;
      end else begin
         cmd_strobe_r <= wr_ok && host_addr == OFS_COMMAND;
         if (wr_ok && host_addr == OFS_COMMAND) begin
            command_r <= merge(command_r, be_mask, host_wdata);
         end
      end
   end
   assign command_word = command_r;
   assign command_strobe = cmd_strobe_r;

   // dynamic flags follow the source; static flags are sticky, set wins over clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_r <= RST_FLAG;
      end else begin
         logic [31:0] nxt;
         nxt = flag_r;
         if (wr_ok && host_addr == OFS_FLAG_NORM) begin
            nxt = merge(flag_r, be_mask, host_wdata);
         end else if (wr_ok && host_addr == OFS_FLAG_CLR) begin
            nxt = flag_r & ~wdata_m;
         end else if (wr_ok && host_addr == OFS_FLAG_SET) begin
            nxt = flag_r | wdata_m;
         end
         flag_r <= (behav_r & hw_flags) | (~behav_r & (nxt | hw_flags));
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_r <= RST_MASK;
         trig_r <= RST_TRIG;
         behav_r <= RST_BEHAV;
      end else if (wr_ok) begin
         unique case (host_addr)
            OFS_MASK_NORM: mask_r <= merge(mask_r, be_mask, host_wdata);
            OFS_MASK_CLR: mask_r <= mask_r & ~wdata_m;
            OFS_MASK_SET: mask_r <= mask_r | wdata_m;
            OFS_TRIG: trig_r <= merge(trig_r, be_mask, host_wdata);
            OFS_BEHAV: behav_r <= merge(behav_r, be_mask, host_wdata);
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         win_r[0] <= '{host_base: RST_W0_HOST, span: RST_W0_SPAN, mem_base: RST_W0_MEM};
         win_r[1] <= '{host_base: RST_W1_HOST, span: RST_W1_SPAN, mem_base: RST_W1_MEM};
         win_en_r <= 1'b0;
      end else if (wr_ok) begin
         unique case (host_addr)
            OFS_W0_HOST: win_r[0].host_base <= 21'(merge({11'h0, win_r[0].host_base}, be_mask, host_wdata));
            OFS_W0_SPAN: win_r[0].span <= 21'(merge({11'h0, win_r[0].span}, be_mask, host_wdata));
            OFS_W1_HOST: win_r[1].host_base <= 21'(merge({11'h0, win_r[1].host_base}, be_mask, host_wdata));
            OFS_W1_SPAN: win_r[1].span <= 21'(merge({11'h0, win_r[1].span}, be_mask, host_wdata));
            OFS_W0_MEM: win_r[0].mem_base <= 24'(merge({8'h0, win_r[0].mem_base}, be_mask, host_wdata));
            OFS_W1_MEM: win_r[1].mem_base <= 24'(merge({8'h0, win_r[1].mem_base}, be_mask, host_wdata));
            OFS_WIN_EN: win_en_r <= host_be[0] ? host_wdata[0] : win_en_r;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         in_up_r <= RST_IN_UP;
         in_lo_r <= RST_IN_LO;
         out_up_r <= RST_OUT_UP;
         out_lo_r <= RST_OUT_LO;
         in_dma_r <= RST_IN_DMA;
         out_dma_r <= RST_OUT_DMA;
         dma_r <= RST_DMA_CTL;
      end else if (wr_ok) begin
         unique case (host_addr)
            OFS_IN_THR: begin
               if (host_be[2]) in_up_r <= host_wdata[23:16];
               if (host_be[0]) in_lo_r <= host_wdata[7:0];
            end
            OFS_OUT_THR: begin
               if (host_be[2]) out_up_r <= host_wdata[23:16];
               if (host_be[0]) out_lo_r <= host_wdata[7:0];
            end
            OFS_IN_DMA: if (host_be[0]) in_dma_r <= host_wdata[7:0];
            OFS_OUT_DMA: if (host_be[2]) out_dma_r <= host_wdata[23:16];
            OFS_DMA_CTL: begin
               if (host_be[1]) dma_r.stop_len <= host_wdata[12:8];
               if (host_be[0]) begin
                  dma_r.float_pins <= host_wdata[4];
                  dma_r.polarity_flip <= host_wdata[3];
                  dma_r.demand_mode <= host_wdata[2];
                  dma_r.enable <= host_wdata[1];
                  dma_r.to_input <= host_wdata[0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // memory window mapping
   // ------------------------------------------------------------
   always_comb begin
      mem_hit = 1'b0;
      mem_addr = '0;
      for (int w = 1; w >= 0; w--) begin
         if (mem_req && win_en_r && mem_host_addr >= win_r[w].host_base
             && mem_host_addr < 21'(win_r[w].host_base + win_r[w].span)) begin
            mem_hit = 1'b1;
            mem_addr = 24'(win_r[w].mem_base + 24'(mem_host_addr - win_r[w].host_base));
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_rdata <= '0;
      end else if (host_rd) begin
         unique case (host_addr)
            OFS_COMMAND: host_rdata <= command_r & be_mask;
            OFS_OUT_Q: host_rdata <= (host_be == 4'hF && out_valid) ? out_data : '0;
            OFS_FLAG_NORM, OFS_FLAG_CLR, OFS_FLAG_SET: host_rdata <= flag_r & be_mask;
            OFS_MASK_NORM, OFS_MASK_CLR, OFS_MASK_SET: host_rdata <= mask_r & be_mask;
            OFS_TRIG: host_rdata <= trig_r & be_mask;
            OFS_W0_HOST: host_rdata <= {11'h0, win_r[0].host_base} & be_mask;
            OFS_W0_SPAN: host_rdata <= {11'h0, win_r[0].span} & be_mask;
            OFS_W1_HOST: host_rdata <= {11'h0, win_r[1].host_base} & be_mask;
            OFS_W1_SPAN: host_rdata <= {11'h0, win_r[1].span} & be_mask;
            OFS_W0_MEM: host_rdata <= {8'h0, win_r[0].mem_base} & be_mask;
            OFS_W1_MEM: host_rdata <= {8'h0, win_r[1].mem_base} & be_mask;
            OFS_WIN_EN: host_rdata <= {31'h0, win_en_r} & be_mask;
            OFS_IN_THR: host_rdata <= {8'h0, in_up_r, 8'h0, in_lo_r} & be_mask;
            OFS_OUT_THR: host_rdata <= {8'h0, out_up_r, 8'h0, out_lo_r} & be_mask;
            OFS_IN_DMA: host_rdata <= {24'h0, in_dma_r} & be_mask;
            OFS_OUT_DMA: host_rdata <= {8'h0, out_dma_r, 16'h0} & be_mask;
            OFS_DMA_CTL: host_rdata <= {19'h0, dma_r.stop_len, 3'h0, dma_r.float_pins, dma_r.polarity_flip,
               dma_r.demand_mode, dma_r.enable, dma_r.to_input} & be_mask;
            OFS_BEHAV: host_rdata <= behav_r & be_mask;
            OFS_DEBUG: host_rdata <= {8'h0, in_load_cmd, out_load, in_load} & be_mask;
            default: host_rdata <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // interrupt: edge or level per flag
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_prev_r <= RST_FLAG;
      end else begin
         flag_prev_r <= flag_r;
      end
   end
   assign irq_src = (trig_r & flag_r & ~flag_prev_r) | (~trig_r & flag_r);
   assign irq_raw = |(irq_src & mask_r);

   // ------------------------------------------------------------
   // dma handshake
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_meta_r <= 1'b0;
         ack_sync_r <= 1'b0;
         ack_prev_r <= 1'b0;
         en_prev_r <= 1'b0;
      end else begin
         ack_meta_r <= dma_ack_pin;
         ack_sync_r <= ack_meta_r;
         ack_prev_r <= ack_sync_r;
         en_prev_r <= dma_r.enable;
      end
   end
   assign ack_rise = ack_sync_r && !ack_prev_r;
   // input side asks while load at or below its limit; output while at or above and not empty
   assign dma_go = dma_r.to_input ? (in_load <= in_dma_r) : (out_load >= out_dma_r && out_load != 8'h00);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_state_r <= DMA_IDLE;
         stop_cnt_r <= '0;
      end else begin
         unique case (dma_state_r)
            DMA_IDLE: begin
               if (dma_r.enable && dma_go) begin
                  dma_state_r <= DMA_REQ;
               end
            end
            DMA_REQ: begin
               if ((en_prev_r && !dma_r.enable) || sw_reset) begin
                  dma_state_r <= DMA_STOP;
                  stop_cnt_r <= dma_r.stop_len;
               end else if (ack_rise && (!dma_r.demand_mode || !dma_go)) begin
                  dma_state_r <= DMA_IDLE;
               end
            end
            DMA_STOP: begin
               if (stop_cnt_r == 5'h00) begin
                  dma_state_r <= DMA_IDLE;
               end else begin
                  stop_cnt_r <= stop_cnt_r - 5'h01;
               end
            end
         endcase
      end
   end
   assign dreq_raw = dma_state_r == DMA_REQ;
   assign dma_stop_pulse_len_raw = dma_state_r == DMA_STOP;

   // ------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------
   assign dma_request_out = dreq_raw ^ dma_r.polarity_flip;
   assign dma_stop_out = dma_stop_pulse_len_raw ^ dma_r.polarity_flip;
   assign interrupt_out = irq_raw ^ dma_r.polarity_flip;
   assign dma_request_oe_b = dma_r.float_pins;
   assign dma_stop_oe_b = dma_r.float_pins;
   assign interrupt_oe_b = dma_r.float_pins;
endmodule

// ---- test/host_bus_unit_asserts.sv ----
// port checker of the host bus unit
`timescale 1ns/1ps
module hbu_asserts
   import hbu_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [3:0] host_be,
   input wire logic [31:0] host_wdata,
   input wire logic [31:0] host_rdata,
   input wire logic host_size_err,
   input wire logic core_in_valid,
   input wire logic [31:0] core_in_data,
   input wire logic [7:0] in_load_cmd,
   input wire logic command_strobe,
   input wire logic dma_request_out,
   input wire logic dma_request_oe_b
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence ctl_wr; host_wr && host_addr == OFS_DMA_CTL && host_be[0]; endsequence
   sequence sw_rst; host_wr && host_addr == OFS_COMMAND && host_be[0] && host_wdata[7:0] == CODE_SW_RESET; endsequence
   sequence push_empty; host_wr && host_addr == OFS_IN_Q && host_be == 4'hF && !core_in_valid; endsequence
   a_size_err_flag: assert property (
      host_wr && host_addr == OFS_IN_Q && host_be != 4'hF |-> host_size_err) else $error("size flag missing");
   a_push_head: assert property (
      push_empty |=> core_in_valid && core_in_data == $past(host_wdata)) else $error("pushed word not at head");
   a_cmd_strobe: assert property (
      host_wr && host_addr == OFS_COMMAND |=> ##[0:1] command_strobe) else $error("no command strobe");
   a_rdata_hold: assert property (
      !host_rd |=> $stable(host_rdata)) else $error("read data moved");
   a_debug_load: assert property (
      host_rd && host_be[2] && host_addr == OFS_DEBUG |=> host_rdata[23:16] == $past(in_load_cmd))
      else $error("debug load wrong");
   a_float_pins: assert property (
      ctl_wr |=> dma_request_oe_b == $past(host_wdata[4])) else $error("float select wrong");
   a_flip_idle: assert property (
      ctl_wr ##0 !host_wdata[1] |=> ##1 dma_request_out == $past(host_wdata[3], 2)) else $error("idle level wrong");
   a_sw_flush: assert property (
      sw_rst |=> ##1 !core_in_valid) else $error("queue kept after reset command");
endmodule
bind host_bus_unit hbu_asserts chk (.*);

// ---- test/host_dma_model.sv ----
// host dma controller model, one acknowledge per request
`timescale 1ns/1ps
module host_dma_model (
   input wire logic core_clk,
   input wire logic req_pin,
   input wire logic flip,
   input wire logic slow,
   output logic ack
);
   int n = 0;
   always @(posedge core_clk) begin
      ack <= 1'b0;
      n <= (req_pin ^ flip) ? n + 1 : 0;
      if ((req_pin ^ flip) && n == (slow ? 6 : 1)) ack <= 1'b1;
   end
endmodule

// ---- test/host_bus_unit_bench.sv ----
// self-checking bench of the host bus unit
`timescale 1ns/1ps
module host_bus_unit_bench;
   import hbu_pkg::*;
   logic core_clk = 0, rst_b = 0, host_wr = 0, host_rd = 0, core_in_ready = 0, core_out_valid = 0;
   logic [7:0] host_addr = 0, in_load_cmd = 8'h5A;
   logic [3:0] host_be = 0;
   logic [31:0] host_wdata = 0, host_rdata, core_in_data, core_out_data = 0, core_flag_set = 0;
   logic [31:0] flag_dynamic, command_word, d;
   logic host_in_ready, host_size_err, core_in_valid, core_out_ready, command_strobe, mem_req = 0, mem_hit;
   logic dma_ack_pin, dma_request_out, dma_request_oe_b, dma_stop_out, dma_stop_oe_b, interrupt_out, interrupt_oe_b;
   logic flip = 0, slow = 0;
   logic [20:0] mem_host_addr = 21'h01_0004;
   logic [23:0] mem_addr;
   int fails = 0, num_checks = 0, n;
   host_bus_unit dut (.*);
   host_dma_model hm (.core_clk, .req_pin(dma_request_out), .flip, .slow, .ack(dma_ack_pin));
   always #12.5 core_clk = ~core_clk;
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(logic [7:0] a, logic [3:0] be, logic [31:0] v);
      @(posedge core_clk) #1 {host_addr, host_be, host_wdata, host_wr} = {a, be, v, 1'b1};
      @(posedge core_clk) #1 host_wr = 0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge core_clk) #1 {host_addr, host_be, host_rd} = {a, 4'hF, 1'b1};
      @(posedge core_clk) #1 host_rd = 0;
      d = host_rdata;
   endtask
   task automatic s_reset();
      logic [39:0] t [17] = '{{OFS_COMMAND, RST_COMMAND}, {OFS_MASK_NORM, RST_MASK}, {OFS_TRIG, RST_TRIG},
         {OFS_W0_HOST, 11'h0, RST_W0_HOST}, {OFS_W0_SPAN, 11'h0, RST_W0_SPAN}, {OFS_W1_HOST, 11'h0, RST_W1_HOST},
         {OFS_W1_SPAN, 11'h0, RST_W1_SPAN}, {OFS_W0_MEM, 8'h0, RST_W0_MEM}, {OFS_W1_MEM, 8'h0, RST_W1_MEM},
         {OFS_WIN_EN, 32'h0}, {OFS_IN_THR, 8'h0, RST_IN_UP, 8'h0, RST_IN_LO}, {OFS_IN_DMA, 24'h0, RST_IN_DMA},
         {OFS_OUT_THR, 8'h0, RST_OUT_UP, 8'h0, RST_OUT_LO}, {OFS_OUT_DMA, 8'h0, RST_OUT_DMA, 16'h0},
         {OFS_DMA_CTL, 19'h0, RST_STOP_LEN, 8'h01}, {OFS_BEHAV, RST_BEHAV}, {8'hFC, 32'h0}};
      foreach (t[i]) begin
         rd(t[i][39:32]);
         chk("reset value", d, t[i][31:0]);
      end
      chk("dynamic", flag_dynamic, RST_BEHAV);
   endtask
   task automatic s_regs();
      wr(OFS_FLAG_CLR, 4'hF, 32'hFFFF_FFFF);
      rd(OFS_FLAG_NORM);
      chk("flag clear", d & 32'hDFBF_FFF0, 32'h0);
      wr(OFS_FLAG_SET, 4'h4, 32'hFFFF_FFFF);
      rd(OFS_FLAG_NORM);
      chk("flag byte set", d & 32'hDFBF_FFF0, 32'h00BF_0000);
      wr(OFS_FLAG_NORM, 4'hF, 32'h1234_5670);
      rd(OFS_FLAG_NORM);
      chk("flag normal", d & 32'hDFBF_FFF0, 32'h1234_5670);
      wr(OFS_MASK_NORM, 4'hF, 32'hFFFF_0000);
      wr(OFS_MASK_CLR, 4'hF, 32'h0F00_0000);
      wr(OFS_MASK_SET, 4'h1, 32'h0000_0101);
      rd(OFS_MASK_NORM);
      chk("mask", d, 32'hF0FF_0001);
      wr(OFS_COMMAND, 4'hF, 32'hABCD_EF12);
      rd(OFS_COMMAND);
      chk("command", d, 32'hABCD_EF12);
      chk("command word", command_word, 32'hABCD_EF12);
      wr(OFS_DEBUG, 4'hF, 32'hFFFF_FFFF);
      rd(OFS_DEBUG);
      chk("debug", d, {8'h0, in_load_cmd, 16'h0});
   endtask
   task automatic s_irq();
      wr(OFS_TRIG, 4'hF, 32'h0);
      wr(OFS_IN_THR, 4'hF, {8'h0, RST_IN_UP, 8'h0, RST_IN_LO});
      wr(OFS_BEHAV, 4'hF, RST_BEHAV);
      wr(OFS_FLAG_CLR, 4'hF, 32'hFFFF_FFFF);
      tick(2);
      chk("irq idle", interrupt_out, 0);
      core_flag_set[16] = 1;
      tick(3);
      chk("irq raised", interrupt_out, 1);
      core_flag_set[16] = 0;
      wr(OFS_MASK_CLR, 4'h4, 32'h0001_0000);
      tick(2);
      chk("irq masked", interrupt_out, 0);
   endtask
   task automatic s_dma();
      slow = 1;
      wr(OFS_OUT_DMA, 4'h4, 32'h0001_0000);
      chk("out ready", core_out_ready, 1);
      {core_out_valid, core_out_data} = {1'b1, 32'hA5A5_0001};
      tick(1);
      core_out_valid = 0;
      wr(OFS_DMA_CTL, 4'hF, 32'h0000_0202);
      tick(1);
      chk("request", dma_request_out, 1);
      rd(OFS_OUT_Q);
      chk("popped", d, 32'hA5A5_0001);
      for (n = 0; n < 30 && dma_request_out; n++) tick(1);
      chk("request released", dma_request_out, 0);
      // re-arm, then drop enable while the request stands
      {core_out_valid, core_out_data} = {1'b1, 32'hA5A5_0002};
      tick(1);
      core_out_valid = 0;
      wr(OFS_DMA_CTL, 4'hF, 32'h0000_0200);
      n = 0;
      for (int i = 0; i < 10; i++) begin
         n += dma_stop_out;
         tick(1);
      end
      chk("stop length", n, 3);
      wr(OFS_DMA_CTL, 4'hF, 32'h0000_0207);
      n = 0;
      tick(1);
      for (int i = 0; i < 20; i++) begin
         n += !dma_request_out;
         tick(1);
      end
      chk("demand held", n, 0);
      wr(OFS_DMA_CTL, 4'hF, 32'h0000_0205);
      tick(5);
      flip = 1;
      wr(OFS_DMA_CTL, 4'hF, 32'h0000_0018);
      chk("pins", {dma_request_out, dma_stop_out, interrupt_out, dma_stop_oe_b, interrupt_oe_b}, 5'h1F);
      flip = 0;
      wr(OFS_DMA_CTL, 4'hF, 32'h0000_0001);
   endtask
   task automatic s_queue();
      for (int i = 0; i < 9; i++) wr(OFS_IN_Q, 4'hF, 32'hC0DE_0000 + i);
      chk("full", host_in_ready, 0);
      rd(OFS_DEBUG);
      chk("loads", d, {8'h0, in_load_cmd, 16'h0108});
      @(posedge core_clk) #1 {host_addr, host_be, host_wr} = {OFS_IN_Q, 4'h3, 1'b1};
      #1 chk("size flag", host_size_err, 1);
      @(posedge core_clk) #1 {host_wr, core_in_ready} = 2'b01;
      for (int i = 0; i < 8; i++) begin
         chk("drain", {core_in_valid, core_in_data}, {1'b1, 32'hC0DE_0000 + i});
         tick(1);
      end
      chk("empty", core_in_valid, 0);
      core_in_ready = 0;
      wr(OFS_IN_Q, 4'hF, 32'h1);
      wr(OFS_COMMAND, 4'h1, 32'h0);
      tick(2);
      chk("flushed", core_in_valid, 0);
   endtask
   task automatic s_window();
      mem_req = 1;
      tick(1);
      chk("window off", mem_hit, 0);
      wr(OFS_WIN_EN, 4'h1, 32'h1);
      chk("window hit", {mem_hit, mem_addr}, {1'b1, RST_W0_MEM + 24'(mem_host_addr - RST_W0_HOST)});
      mem_req = 0;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      tick(8);
      rst_b = 1;
      s_reset();
      s_regs();
      s_irq();
      s_dma();
      s_queue();
      s_window();
      print_verdict();
   end
   initial begin
      #500000;
      fails++;
      print_verdict();
   end
endmodule
